//--- verilog/kwdt_top.sv
// Function
// RL1 - After reset: plain 64-bit timer, watchdog off, all controls still writable.
// RL2 - Watchdog selected only when mode select is 10b and enable bit is 1.
// RL3 - Once watchdog selected, mode stays locked until hardware reset, or software reset before active.
// RL4 - Watchdog refuses dual, gated, external clock, one-time and clock output setups.
// RL5 - Watchdog forces output mode to pulse; software picks internal clock.
// RL6 - Four counter words form one 64-bit up-counter, period words likewise.
// RL7 - Count equal period: event, counter to zero, status set; flag set only in active watchdog.
// RL8 - Service is first key then second key; it clears the counter.
// RL9 - In active state any other key write times out immediately.
// RL10 - Active state: any control-one write times out; reads do nothing.
// RL11 - Active watchdog stops only by timeout or hardware reset.
// RL12 - Timeout state disables watchdog, clears enable, resets timer, no re-enable.
// RL13 - Enable writes are ignored in the timeout state.
// RL14 - Initial to pre-active when enabled and first key written.
// RL15 - Pre-active control-one write accepted only with a valid key alongside.
// RL16 - Pre-active second key with enable set clears counter, enters active.
// RL17 - Output pin never pulses before active; interrupt pulses on every match.
// RL18 - From pre-active on, counter, period and timer control writes blocked.
// RL19 - Software must not write the mode select after the initial state.
// RL20 - Interrupt routes to none, interrupt three, reset or NMI; none by default.
// RL21 - Pin as watchdog output and NMI route: external pin level ignored.
// RL22 - Idle permitted after idle keys 01b then 10b; 00b forbids it.
// RL23 - Permitted idle request stops counting at once.
// RL24 - Pulse width field sets each output pulse length.
// RL25 - Key tracker waits for first key again after service or reset.
// RL26 - Reset clears state, enable, flag, idle permission, counter and period.
`timescale 1ns/10ps
`default_nettype none

module kwdt_top
	import kwdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic soft_reset_i,
	input wire logic gctl_wr_i,
	input wire logic [1:0] timer_mode_select_i,
	input wire logic tctl_wr_i,
	input wire logic [1:0] enabling_mode_field_i,
	input wire logic output_mode_select_i,
	input wire logic clock_source_select_i,
	input wire logic gated_clock_i,
	input wire logic [1:0] pulse_width_field_i,
	input wire logic [3:0] cnt_wr_i,
	input wire logic [3:0] prd_wr_i,
	input wire logic [15:0] word_i,
	input wire logic wctl1_wr_i,
	input wire logic watchdog_enable_bit_i,
	input wire logic [1:0] idle_key_field_i,
	input wire logic flag_clr_i,
	input wire logic [15:0] wctl1_key_i,
	input wire logic wctl2_wr_i,
	input wire logic [15:0] service_key_field_i,
	input wire logic route_wr_i,
	input wire logic [1:0] interrupt_route_select_i,
	input wire logic shared_pin_function_select_i,
	input wire logic shared_pin_direction_select_i,
	input wire logic nmi_pin_i,
	input wire logic peripheral_domain_idle_bit_i,
	input wire logic idle_instr_i,
	input wire logic wake_i,
	output logic [63:0] counter_o,
	output logic [63:0] period_o,
	output logic [1:0] wd_state_o,
	output logic wd_mode_o,
	output logic watchdog_enable_bit_o,
	output logic timeout_flag_o,
	output logic timer_status_bit_o,
	output logic idle_o,
	output logic watchdog_interrupt_signal_o,
	output logic maskable_interrupt_three_req_o,
	output logic reset_req_o,
	output logic nmi_o,
	output logic watchdog_output_pin_o,
	output logic watchdog_output_pin_oe_n_o
);

	typedef struct packed {
		kwdt_state_e st;
		logic [1:0] mode;
		logic lock;
		logic en;
		logic key_half;
		logic ikey_half;
		logic idle_ok;
		logic idle;
		logic [KWDT_CNT_W-1:0] cnt;
		logic [KWDT_CNT_W-1:0] prd;
		logic [1:0] ena;
		logic cp;
		logic clock_source_select;
		logic [1:0] pulse_width_field;
		logic [1:0] route;
		logic flag;
		logic [2:0] pin_sync;
		logic pin_val;
		logic timer_interrupt_signal_trig;
		logic wd_trig;
	} kwdt_regs_s;

	kwdt_regs_s r;
	kwdt_regs_s next_r;
	logic wd_sel;
	logic run;
	logic match;
	logic key1;
	logic key2;
	logic wctl1_ok;
	logic timer_interrupt_signal_pulse;
	logic wd_pulse;

	function automatic logic is_key(input logic [15:0] k);
		is_key = (k == KWDT_KEY_FIRST) || (k == KWDT_KEY_SECOND);
	endfunction : is_key

	assign wd_sel = (r.mode == KWDT_MODE_WD) && r.en; // [RL2]
	assign run = !r.idle && (r.st == KWDT_ST_ACTIVE
		|| (r.ena != KWDT_ENA_OFF && r.st != KWDT_ST_TIMEOUT)); // [RL23]
	assign match = run && (r.cnt == r.prd); // [RL6]
	assign key1 = wctl2_wr_i && (service_key_field_i == KWDT_KEY_FIRST);
	assign key2 = wctl2_wr_i && (service_key_field_i == KWDT_KEY_SECOND);
	// Pre-active control writes need a valid key riding on the same access
	assign wctl1_ok = wctl1_wr_i && (r.st == KWDT_ST_INIT
		|| (r.st == KWDT_ST_PREACT && is_key(wctl1_key_i))); // [RL15]

	always_comb begin
		logic to_evt;
		logic prot;
		to_evt = 1'b0;
		prot = (r.st != KWDT_ST_INIT);
		next_r = r;
		next_r.timer_interrupt_signal_trig = 1'b0;
		next_r.wd_trig = 1'b0;
		// Only the second and third stages are compared
		next_r.pin_sync = {r.pin_sync[1:0], nmi_pin_i};
		if (r.pin_sync[1] == r.pin_sync[2]) begin
			next_r.pin_val = r.pin_sync[2];
		end

		if (match) begin
			next_r.cnt = KWDT_CNT_RESET; // [RL7]
			next_r.timer_interrupt_signal_trig = 1'b1; // [RL17]
			if (r.ena == KWDT_ENA_ONCE && r.st != KWDT_ST_ACTIVE) begin
				next_r.ena = KWDT_ENA_OFF;
			end
		end else if (run) begin
			next_r.cnt = r.cnt + 64'h1; // [RL6]
		end

		for (int i = 0; i < KWDT_WORDS; i++) begin
			if (cnt_wr_i[i] && !prot) begin
				next_r.cnt[KWDT_WORD_W*i +: KWDT_WORD_W] = word_i; // [RL6] [RL18]
			end
			if (prd_wr_i[i] && !prot) begin
				next_r.prd[KWDT_WORD_W*i +: KWDT_WORD_W] = word_i; // [RL6] [RL18]
			end
		end

		if (tctl_wr_i && !prot && !(wd_sel && (enabling_mode_field_i == KWDT_ENA_ONCE
			|| output_mode_select_i || clock_source_select_i || gated_clock_i))) begin // [RL4]
			next_r.ena = enabling_mode_field_i;
			next_r.cp = output_mode_select_i;
			next_r.clock_source_select = clock_source_select_i;
			next_r.pulse_width_field = pulse_width_field_i; // [RL24]
		end
		if (wd_sel) begin
			next_r.cp = 1'b0; // [RL5]
			next_r.lock = 1'b1; // [RL3]
		end
		if (gctl_wr_i && !r.lock) begin
			next_r.mode = timer_mode_select_i; // [RL3]
		end
		if (route_wr_i) begin
			next_r.route = interrupt_route_select_i; // [RL20]
		end

		if (wctl1_ok) begin
			next_r.en = watchdog_enable_bit_i;
			unique case (idle_key_field_i)
				KWDT_IKEY_FIRST: begin
					next_r.ikey_half = 1'b1; // [RL22]
				end
				KWDT_IKEY_SECOND: begin
					next_r.idle_ok = r.ikey_half; // [RL22]
					next_r.ikey_half = 1'b0;
				end
				KWDT_IKEY_FORBID: begin
					next_r.idle_ok = 1'b0; // [RL22]
					next_r.ikey_half = 1'b0;
				end
				default: begin
				end
			endcase
		end
		if (wctl1_wr_i && flag_clr_i) begin
			next_r.flag = 1'b0;
		end

		unique case (r.st)
			KWDT_ST_INIT: begin
				if (wd_sel && key1) begin
					next_r.st = KWDT_ST_PREACT; // [RL14]
				end
			end
			KWDT_ST_PREACT: begin
				if (key2 && r.en) begin
					next_r.st = KWDT_ST_ACTIVE; // [RL16]
					next_r.cnt = KWDT_CNT_RESET;
					next_r.ena = KWDT_ENA_CONT; // [RL4]
					next_r.key_half = 1'b0; // [RL25]
				end
			end
			KWDT_ST_ACTIVE: begin
				next_r.en = r.en; // [RL11]
				if (wctl1_wr_i) begin
					to_evt = 1'b1; // [RL10]
				end
				if (key1) begin
					next_r.key_half = 1'b1; // [RL8]
				end else if (key2 && r.key_half) begin
					next_r.cnt = KWDT_CNT_RESET; // [RL8]
					next_r.key_half = 1'b0; // [RL25]
				end else if (wctl2_wr_i) begin
					to_evt = 1'b1; // [RL9]
				end
				if (match) begin
					to_evt = 1'b1; // [RL7]
				end
			end
			KWDT_ST_TIMEOUT: begin
				next_r.en = 1'b0; // [RL12] [RL13]
			end
		endcase

		if (soft_reset_i && !r.st[1]) begin
			// Software reset undoes the lock only before the active state, so it never halts an active watchdog
			next_r.lock = 1'b0; // [RL3]
			next_r.en = 1'b0;
			next_r.mode = KWDT_MODE_GP64;
			next_r.st = KWDT_ST_INIT;
			next_r.key_half = 1'b0;
		end

		if (to_evt) begin
			next_r.st = KWDT_ST_TIMEOUT; // [RL12]
			next_r.en = 1'b0;
			next_r.cnt = KWDT_CNT_RESET;
			next_r.ena = KWDT_ENA_OFF;
			next_r.key_half = 1'b0;
			next_r.flag = 1'b1; // [RL7]
			next_r.timer_interrupt_signal_trig = 1'b1;
			next_r.wd_trig = 1'b1; // [RL17]
		end

		if (wake_i) begin
			next_r.idle = 1'b0;
		end else if (idle_instr_i && peripheral_domain_idle_bit_i
			&& (!(r.en || r.st == KWDT_ST_ACTIVE) || r.idle_ok)) begin
			next_r.idle = 1'b1; // [RL23]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			r <= '0; // [RL1] [RL26]
			r.st <= KWDT_ST_INIT;
			r.mode <= KWDT_MODE_GP64;
			r.ena <= KWDT_ENA_OFF;
			r.pulse_width_field <= KWDT_PULSE_WIDTH_FIELD_RESET;
			r.route <= KWDT_ROUTE_NONE; // [RL20]
			r.pin_sync <= KWDT_SYNC_RESET;
			r.pin_val <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	kwdt_pulse u_timer_interrupt_signal_pulse (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.trig_i(r.timer_interrupt_signal_trig),
		.width_i(r.pulse_width_field), // [RL24]
		.pulse_o(timer_interrupt_signal_pulse)
	);

	kwdt_pulse u_wd_pulse (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.trig_i(r.wd_trig),
		.width_i(r.pulse_width_field), // [RL24]
		.pulse_o(wd_pulse)
	);

	assign counter_o = r.cnt;
	assign period_o = r.prd;
	assign wd_state_o = r.st;
	assign wd_mode_o = wd_sel;
	assign watchdog_enable_bit_o = r.en;
	assign timeout_flag_o = r.flag;
	assign timer_status_bit_o = timer_interrupt_signal_pulse; // [RL7]
	assign idle_o = r.idle;
	assign watchdog_interrupt_signal_o = timer_interrupt_signal_pulse;
	assign maskable_interrupt_three_req_o = timer_interrupt_signal_pulse && (r.route == KWDT_ROUTE_MASKABLE_INTERRUPT_THREE); // [RL20]
	assign reset_req_o = timer_interrupt_signal_pulse && (r.route == KWDT_ROUTE_RESET); // [RL20]
	// The pin is active low; its level is ignored when the pin is selected for the watchdog and the route is NMI or the pin is an output
	assign nmi_o = (timer_interrupt_signal_pulse && r.route == KWDT_ROUTE_NMI)
		|| (!(shared_pin_function_select_i && r.route == KWDT_ROUTE_NMI)
		&& !(shared_pin_function_select_i && shared_pin_direction_select_i)
		&& !r.pin_val); // [RL21]
	assign watchdog_output_pin_o = !wd_pulse; // [RL17]
	assign watchdog_output_pin_oe_n_o = !(shared_pin_function_select_i
		&& shared_pin_direction_select_i);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_first_key;
		r.st == KWDT_ST_ACTIVE && key1 && !wctl1_wr_i && !match;
	endsequence
	sequence s_second_key;
		key2 && !wctl1_wr_i && !match && !soft_reset_i;
	endsequence

	AST_RESET_INIT: assert property ( // [RL26]
		$rose(resetn_i) |-> r.st == KWDT_ST_INIT && !r.en && !r.flag && r.prd == 64'h0)
		else $error("state not cleared by reset");
	AST_LOCK: assert property ( // [RL3]
		r.lock && !soft_reset_i |=> r.lock && $stable(r.mode))
		else $error("mode lock lost");
	AST_CP0: assert property (wd_sel |=> !r.cp) // [RL5]
		else $error("pulse mode not forced");
	AST_SERVICE: assert property ( // [RL8]
		s_first_key ##1 s_second_key |=> r.st == KWDT_ST_ACTIVE && r.cnt == 64'h0 && !r.key_half)
		else $error("service sequence did not clear counter");
	AST_BADKEY: assert property ( // [RL9]
		r.st == KWDT_ST_ACTIVE && wctl2_wr_i && !key1 && !(key2 && r.key_half)
		|=> r.st == KWDT_ST_TIMEOUT && r.flag)
		else $error("bad key did not time out");
	AST_WCTL1_ACTIVE: assert property ( // [RL10]
		r.st == KWDT_ST_ACTIVE && wctl1_wr_i |=> r.st == KWDT_ST_TIMEOUT && !r.en)
		else $error("control write did not time out");
	AST_MATCH: assert property ( // [RL7]
		r.st == KWDT_ST_ACTIVE && match |=> r.st == KWDT_ST_TIMEOUT && r.cnt == 64'h0
		##1 timer_status_bit_o && !watchdog_output_pin_o)
		else $error("match did not raise timeout");
	AST_TIMEOUT_HOLD: assert property ( // [RL12]
		r.st == KWDT_ST_TIMEOUT |=> r.st == KWDT_ST_TIMEOUT && !r.en && !run)
		else $error("timeout state left");
	AST_PREACT: assert property ( // [RL14]
		r.st == KWDT_ST_INIT && wd_sel && key1 && !soft_reset_i |=> r.st == KWDT_ST_PREACT)
		else $error("no pre-active entry");
	AST_ACTIVATE: assert property ( // [RL16]
		r.st == KWDT_ST_PREACT && r.en && key2 && !soft_reset_i
		|=> r.st == KWDT_ST_ACTIVE && r.cnt == 64'h0)
		else $error("no activation");
	AST_PROTECT: assert property (r.st != KWDT_ST_INIT |=> $stable(r.prd)) // [RL18]
		else $error("period written while protected");
	AST_PIN_QUIET: assert property (!watchdog_output_pin_o |-> r.st == KWDT_ST_TIMEOUT) // [RL17]
		else $error("watchdog pin asserted before active");

endmodule : kwdt_top
`default_nettype wire

//--- verilog/kwdt_pkg.sv
package kwdt_pkg;

	typedef enum logic [1:0] {
		KWDT_ST_INIT = 2'h0,
		KWDT_ST_PREACT = 2'h1,
		KWDT_ST_ACTIVE = 2'h3,
		KWDT_ST_TIMEOUT = 2'h2
	} kwdt_state_e;

	localparam int KWDT_WORD_W = 16;
	localparam int KWDT_WORDS = 4;
	localparam int KWDT_CNT_W = KWDT_WORD_W * KWDT_WORDS;

	localparam logic [15:0] KWDT_KEY_FIRST = 16'hA5C6;
	localparam logic [15:0] KWDT_KEY_SECOND = 16'hDA7E;

	localparam logic [1:0] KWDT_MODE_GP64 = 2'h0;
	localparam logic [1:0] KWDT_MODE_WD = 2'h2;

	localparam logic [1:0] KWDT_ENA_OFF = 2'h0;
	localparam logic [1:0] KWDT_ENA_ONCE = 2'h1;
	localparam logic [1:0] KWDT_ENA_CONT = 2'h2;

	localparam logic [1:0] KWDT_IKEY_FORBID = 2'h0;
	localparam logic [1:0] KWDT_IKEY_FIRST = 2'h1;
	localparam logic [1:0] KWDT_IKEY_SECOND = 2'h2;

	localparam logic [1:0] KWDT_ROUTE_NONE = 2'h0;
	localparam logic [1:0] KWDT_ROUTE_MASKABLE_INTERRUPT_THREE = 2'h1;
	localparam logic [1:0] KWDT_ROUTE_RESET = 2'h2;
	localparam logic [1:0] KWDT_ROUTE_NMI = 2'h3;

	localparam logic [1:0] KWDT_PULSE_WIDTH_FIELD_RESET = 2'h0;
	localparam logic [KWDT_CNT_W-1:0] KWDT_CNT_RESET = 64'h0;
	localparam logic [2:0] KWDT_SYNC_RESET = 3'h7;

endpackage : kwdt_pkg

//--- verilog/kwdt_pulse.sv
`timescale 1ns/10ps
`default_nettype none

// Stretches a one-cycle trigger into a pulse of width+1 clock cycles
module kwdt_pulse
	import kwdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic trig_i,
	input wire logic [1:0] width_i,
	output logic pulse_o
);

	typedef struct packed {
		logic busy;
		logic [1:0] left;
	} kwdt_pulse_s;

	kwdt_pulse_s r;
	kwdt_pulse_s next_r;

	always_comb begin
		next_r = r;
		if (trig_i) begin
			// A retrigger restarts the width, so back-to-back events merge
			next_r.busy = 1'b1;
			next_r.left = width_i;
		end else if (r.busy) begin
			if (r.left == 2'h0) begin
				next_r.busy = 1'b0;
			end else begin
				next_r.left = r.left - 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pulse_o = r.busy;

endmodule : kwdt_pulse
`default_nettype wire

//--- verification/kwdt_sw_model.sv
`timescale 1ns/10ps
`default_nettype none

// Software side: writes service keys over the bus, either one key or a full service
module kwdt_sw_model
	import kwdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic svc_i,
	input wire logic one_i,
	input wire logic slow_i,
	input wire logic [15:0] key_i,
	output var logic wr_o,
	output var logic [15:0] key_o,
	output var logic done_o
);
	initial begin
		wr_o = 1'b0;
		key_o = 16'h0;
		done_o = 1'b0;
		forever begin
			@(posedge clk_i);
			done_o <= 1'b0;
			if (svc_i) begin
				wr_o <= 1'b1;
				key_o <= KWDT_KEY_FIRST;
				@(posedge clk_i);
				if (slow_i) begin
					// Released bus shows inverted data, never the stale key
					wr_o <= 1'b0;
					key_o <= ~KWDT_KEY_FIRST;
					repeat (3) @(posedge clk_i);
					wr_o <= 1'b1;
				end
				key_o <= KWDT_KEY_SECOND;
				@(posedge clk_i);
				wr_o <= 1'b0;
				key_o <= ~KWDT_KEY_SECOND;
				done_o <= 1'b1;
			end else if (one_i) begin
				wr_o <= 1'b1;
				key_o <= key_i;
				@(posedge clk_i);
				wr_o <= 1'b0;
				key_o <= ~key_i;
				done_o <= 1'b1;
			end
		end
	end
endmodule : kwdt_sw_model

`default_nettype wire

//--- verification/kwdt_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module kwdt_top_tb import kwdt_pkg::*;;
	logic clk_i = 1'b0, resetn_i = 1'b0, soft_reset_i = 1'b0, gctl_wr_i = 1'b0;
	logic tctl_wr_i = 1'b0, gated = 1'b0, wctl1_wr_i = 1'b0, en = 1'b0, route_wr_i = 1'b0;
	logic nmi_pin_i = 1'b1, idle_instr_i = 1'b0, wake_i = 1'b0, fsel = 1'b0;
	logic svc = 1'b0, one = 1'b0, slow = 1'b0, swr, done;
	logic [1:0] mode = 2'h0, ena = 2'h0, pulse_width_field = 2'h0, ikey = 2'h0, rsel = 2'h0, wd_state_o;
	logic [3:0] cnt_wr = 4'h0, prd_wr = 4'h0;
	logic [15:0] word = 16'h0, wkey = 16'h0, mkey = 16'h0, skey;
	logic [63:0] counter_o, period_o, c;
	logic wd_mode_o, en_o, flag_o, tsb_o, idle_o, wint_o, maskable_interrupt_three_o, rst_o, nmi_o, pin_o, oe_n_o;
	int fail_count = 0, compares = 0, low_n = 0, rq_n = 0, lb, rb;

	kwdt_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
		.gctl_wr_i(gctl_wr_i), .timer_mode_select_i(mode), .tctl_wr_i(tctl_wr_i),
		.enabling_mode_field_i(ena), .output_mode_select_i(1'b0), .clock_source_select_i(1'b0),
		.gated_clock_i(gated), .pulse_width_field_i(pulse_width_field), .cnt_wr_i(cnt_wr), .prd_wr_i(prd_wr),
		.word_i(word), .wctl1_wr_i(wctl1_wr_i), .watchdog_enable_bit_i(en),
		.idle_key_field_i(ikey), .flag_clr_i(1'b0), .wctl1_key_i(wkey), .wctl2_wr_i(swr),
		.service_key_field_i(skey), .route_wr_i(route_wr_i), .interrupt_route_select_i(rsel),
		.shared_pin_function_select_i(fsel), .shared_pin_direction_select_i(fsel),
		.nmi_pin_i(nmi_pin_i), .peripheral_domain_idle_bit_i(1'b1), .idle_instr_i(idle_instr_i),
		.wake_i(wake_i), .counter_o(counter_o), .period_o(period_o), .wd_state_o(wd_state_o),
		.wd_mode_o(wd_mode_o), .watchdog_enable_bit_o(en_o), .timeout_flag_o(flag_o),
		.timer_status_bit_o(tsb_o), .idle_o(idle_o), .watchdog_interrupt_signal_o(wint_o),
		.maskable_interrupt_three_req_o(maskable_interrupt_three_o), .reset_req_o(rst_o), .nmi_o(nmi_o), .watchdog_output_pin_o(pin_o),
		.watchdog_output_pin_oe_n_o(oe_n_o));

	kwdt_sw_model sw (.clk_i(clk_i), .svc_i(svc), .one_i(one), .slow_i(slow), .key_i(mkey),
		.wr_o(swr), .key_o(skey), .done_o(done));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// Running totals let pulse widths be checked after the fact
	always @(posedge clk_i) begin
		low_n <= low_n + int'(!pin_o);
		rq_n <= rq_n + int'(rst_o);
	end

	task automatic end_of_test();
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wait_on(input int sel);
		int n;
		n = 0;
		while (!(sel == 0 ? wint_o === 1'b1 : done === 1'b1)) begin
			@(negedge clk_i);
			n++;
			if (n > 300) begin
				fail_count++;
				$display("[ERR] %0t wait timed out", $time);
				end_of_test();
			end
		end
	endtask : wait_on

	task automatic rst();
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(negedge clk_i);
	endtask : rst

	// One register write; strobe and its data rise together, the strobe drops a cycle later, the data stays
	task automatic wr(input int s, input logic [1:0] a, input logic b, input logic [15:0] k);
		@(posedge clk_i);
		case (s)
			0: mode <= a;
			1: {ena, gated, pulse_width_field} <= {a, b, k[1:0]};
			2: {en, ikey, wkey} <= {b, a, k};
			3: {rsel, fsel, nmi_pin_i} <= {a, b, ~b};
			7: slow <= b;
			8: mkey <= k;
			9: {cnt_wr, word} <= {4'h1 << a, k};
			10: {prd_wr, word} <= {4'h1 << a, k};
			default: ;
		endcase
		case (s)
			0: gctl_wr_i <= 1'b1;
			1: tctl_wr_i <= 1'b1;
			2: wctl1_wr_i <= 1'b1;
			3: route_wr_i <= 1'b1;
			4: idle_instr_i <= 1'b1;
			5: wake_i <= 1'b1;
			6: soft_reset_i <= 1'b1;
			7: svc <= 1'b1;
			8: one <= 1'b1;
			default: ;
		endcase
		@(posedge clk_i);
		{gctl_wr_i, tctl_wr_i, wctl1_wr_i, route_wr_i, idle_instr_i} <= 5'h0;
		{wake_i, soft_reset_i, svc, one} <= 4'h0;
		cnt_wr <= 4'h0;
		prd_wr <= 4'h0;
		if (s == 7 || s == 8) wait_on(2);
		@(negedge clk_i);
	endtask : wr

	initial begin
		rst();
		chk(wd_state_o, KWDT_ST_INIT, "reset state");
		chk({wd_mode_o, en_o, flag_o, idle_o, pin_o, nmi_o}, 6'h02, "reset flags");
		chk(counter_o | period_o, 64'h0, "reset count");
		wr(10, 2'h0, 1'b0, 16'h0006);
		wr(9, 2'h3, 1'b0, 16'h0001);
		chk(counter_o, 64'h0001_0000_0000_0000, "count words");
		chk(period_o, 64'h6, "period words");
		wr(9, 2'h3, 1'b0, 16'h0000);
		wr(3, KWDT_ROUTE_MASKABLE_INTERRUPT_THREE, 1'b0, 16'h0);
		wr(1, KWDT_ENA_CONT, 1'b0, 16'h0);
		wait_on(0);
		chk(counter_o, 64'h1, "match clears");
		chk({tsb_o, maskable_interrupt_three_o, rst_o, pin_o, flag_o}, 5'h1A, "gp match");

		rst();
		wr(10, 2'h0, 1'b0, 16'h0028);
		wr(0, KWDT_MODE_WD, 1'b0, 16'h0);
		wr(3, KWDT_ROUTE_RESET, 1'b0, 16'h0);
		wr(2, KWDT_IKEY_FORBID, 1'b1, 16'h0);
		chk(wd_mode_o, 1'b1, "wd mode");
		wr(1, KWDT_ENA_CONT, 1'b1, 16'h0);
		repeat (4) @(negedge clk_i);
		chk(counter_o, 64'h0, "gated refused");
		wr(1, KWDT_ENA_CONT, 1'b0, 16'h0002);
		wr(8, 2'h0, 1'b0, KWDT_KEY_FIRST);
		chk(wd_state_o, KWDT_ST_PREACT, "preactive");
		wr(10, 2'h0, 1'b0, 16'h0005);
		chk(period_o, 64'h28, "period locked");
		wr(2, KWDT_IKEY_FORBID, 1'b0, 16'h0);
		chk(en_o, 1'b1, "keyless ctl1");
		wr(2, KWDT_IKEY_FIRST, 1'b1, KWDT_KEY_FIRST);
		wr(4, 2'h0, 1'b0, 16'h0);
		@(negedge clk_i);
		chk(idle_o, 1'b0, "idle refused");
		wr(2, KWDT_IKEY_SECOND, 1'b1, KWDT_KEY_SECOND);
		wr(8, 2'h0, 1'b0, KWDT_KEY_SECOND);
		chk(wd_state_o, KWDT_ST_ACTIVE, "active");
		chk(counter_o < 64'h4, 1'b1, "armed count");
		for (int i = 0; i < 3; i++) begin
			repeat (25) @(negedge clk_i);
			wr(7, 2'h0, i[0], 16'h0);
		end
		chk(wd_state_o, KWDT_ST_ACTIVE, "serviced");
		wr(4, 2'h0, 1'b0, 16'h0);
		@(negedge clk_i);
		chk(idle_o, 1'b1, "idle");
		c = counter_o;
		repeat (5) @(negedge clk_i);
		chk(counter_o, c, "frozen");
		wr(5, 2'h0, 1'b0, 16'h0);
		wr(6, 2'h0, 1'b0, 16'h0);
		chk(wd_state_o, KWDT_ST_ACTIVE, "soft reset");
		lb = low_n;
		rb = rq_n;
		wr(8, 2'h0, 1'b0, KWDT_KEY_SECOND);
		repeat (8) @(negedge clk_i);
		chk(wd_state_o, KWDT_ST_TIMEOUT, "lone key");
		chk({en_o, flag_o, rst_o, pin_o}, 4'h5, "timeout");
		chk(low_n - lb, 3, "pin width");
		chk(rq_n - rb, 3, "reset route");
		wr(2, KWDT_IKEY_FORBID, 1'b1, KWDT_KEY_FIRST);
		chk(en_o, 1'b0, "enable ignored");
		wr(7, 2'h0, 1'b0, 16'h0);
		chk(wd_state_o, KWDT_ST_TIMEOUT, "no rearm");

		rst();
		wr(10, 2'h0, 1'b0, 16'h0028);
		wr(0, KWDT_MODE_WD, 1'b0, 16'h0);
		wr(3, KWDT_ROUTE_NMI, 1'b1, 16'h0);
		wr(2, KWDT_IKEY_FORBID, 1'b1, 16'h0);
		wr(1, KWDT_ENA_CONT, 1'b0, 16'h0);
		wr(8, 2'h0, 1'b0, KWDT_KEY_FIRST);
		wr(8, 2'h0, 1'b0, KWDT_KEY_SECOND);
		chk({nmi_o, oe_n_o}, 2'h0, "pin ignored");
		wr(2, KWDT_IKEY_FORBID, 1'b1, 16'h0);
		wait_on(0);
		chk({nmi_o, wd_state_o}, {1'b1, KWDT_ST_TIMEOUT}, "ctl1 write");
		end_of_test();
	end
endmodule : kwdt_top_tb

`default_nettype wire
